// ==== design/dpram_host_pkg.sv ====
// Package for the host-side dual-port SRAM port sequencer.
// Assumes a single 100 MHz clock and a synchronous, active-high reset.
package dpram_host_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ODR_W = 5;
    localparam logic [ADDR_W-1:0] RIGHT_MAILBOX_ADDR = 14'h3FFF;
    localparam logic [ADDR_W-1:0] LEFT_MAILBOX_ADDR = 14'h3FFE;
    localparam logic [ADDR_W-1:0] OUTPUT_DRIVE_ADDR = 14'h0001;
    localparam logic [DATA_W-1:0] ODR_FIELD_MASK = 16'h001F;

    // ------------------------------------------------------------
    // Mode select encoding
    // ------------------------------------------------------------
    localparam logic MODE_STANDARD = 1'b0;
    localparam logic MODE_MUXED = 1'b1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_SETUP_NS = 20;
    localparam int ADDR_HOLD_NS = 10;
    localparam int ACCESS_NS = 90;
    localparam int WRITE_PULSE_NS = 60;
    localparam int DATA_HOLD_NS = 10;
    localparam int RECOVERY_NS = 20;
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic high_byte_en;
        logic low_byte_en;
    } host_req_t;

    typedef struct packed {
        logic chip_select_n;
        logic write_enable_n;
        logic output_enable_n;
        logic address_latch_strobe_n;
        logic high_byte_enable_n;
        logic low_byte_enable_n;
    } port_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_HOLD = 3'b010,
        ST_READ = 3'b011,
        ST_WRITE = 3'b100,
        ST_DHOLD = 3'b101,
        ST_RECOVER = 3'b110
    } seq_state_t;

    // Idle control levels: deselected, every strobe inactive
    localparam port_ctrl_t CTRL_IDLE = 6'h3F;

    // Count a whole number of cycles into the timer width
    function automatic logic [CNT_W-1:0] cycles(input int n);
        cycles = CNT_W'(n - 1);
    endfunction

endpackage

// ==== design/dpram_port_seq.sv ====
// One host-side port sequencer for the dual-port SRAM.
// Assumes the caller holds req stable while req_valid is high and not taken.
module dpram_port_seq
    import dpram_host_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic muxed,
    input wire logic req_valid,
    input wire host_req_t req,
    output logic req_ready,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output port_ctrl_t ctrl,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] dq_out,
    output logic [1:0] dq_oe,
    input wire logic [DATA_W-1:0] dq_in
);

    seq_state_t state, next_state;
    logic [CNT_W-1:0] timer, next_timer;
    host_req_t held, next_held;
    port_ctrl_t next_ctrl;
    logic [ADDR_W-1:0] next_addr_out;
    logic [DATA_W-1:0] next_dq_out, next_rdata;
    logic [1:0] next_dq_oe;
    logic next_done;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    // Outputs are registered so pins never glitch; cost is one cycle of latency
    always_comb begin
        next_state = state;
        next_timer = (timer != '0) ? timer - 1'b1 : timer;
        next_held = held;
        next_ctrl = ctrl;
        next_addr_out = addr_out;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        next_rdata = rdata;
        next_done = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_ctrl = CTRL_IDLE;
                next_dq_oe = 2'b00;
                if (req_valid) begin
                    next_held = req;
                    next_ctrl.chip_select_n = 1'b0;
                    next_ctrl.high_byte_enable_n = ~req.high_byte_en;
                    next_ctrl.low_byte_enable_n = ~req.low_byte_en;
                    if (muxed) begin
                        // Address goes out on the shared bus with the strobe low
                        next_dq_out = DATA_W'(req.addr);
                        next_dq_oe = 2'b11;
                        next_ctrl.address_latch_strobe_n = 1'b0;
                        next_timer = cycles(ADDR_SETUP_CYC);
                        next_state = ST_ADDR;
                    end else begin
                        next_addr_out = req.addr;
                        next_ctrl.write_enable_n = ~req.write;
                        next_ctrl.output_enable_n = req.write;
                        if (req.write) begin
                            next_dq_out = req.wdata;
                            next_dq_oe = {req.high_byte_en, req.low_byte_en};
                            next_timer = cycles(WRITE_PULSE_CYC);
                            next_state = ST_WRITE;
                        end else begin
                            next_timer = cycles(ACCESS_CYC);
                            next_state = ST_READ;
                        end
                    end
                end
            end
            ST_ADDR: if (timer == '0) begin
                // Rising strobe edge latches the address inside the device
                next_ctrl.address_latch_strobe_n = 1'b1;
                next_timer = cycles(ADDR_HOLD_CYC);
                next_state = ST_HOLD;
            end
            ST_HOLD: if (timer == '0) begin
                next_ctrl.write_enable_n = ~held.write;
                if (held.write) begin
                    next_dq_out = held.wdata;
                    next_dq_oe = {held.high_byte_en, held.low_byte_en};
                    next_timer = cycles(WRITE_PULSE_CYC);
                    next_state = ST_WRITE;
                end else begin
                    next_dq_oe = 2'b00;
                    next_ctrl.output_enable_n = 1'b0;
                    next_timer = cycles(ACCESS_CYC);
                    next_state = ST_READ;
                end
            end
            ST_READ: if (timer == '0) begin
                // Bytes not enabled float at the device, so they read as zero here
                next_rdata[BYTE_W-1:0] = held.low_byte_en ? dq_in[BYTE_W-1:0] : '0;
                next_rdata[DATA_W-1:BYTE_W] =
                    held.high_byte_en ? dq_in[DATA_W-1:BYTE_W] : '0;
                next_ctrl = CTRL_IDLE;
                next_done = 1'b1;
                next_timer = cycles(RECOVERY_CYC);
                next_state = ST_RECOVER;
            end
            ST_WRITE: if (timer == '0) begin
                // Raising write enable commits; data stays for the hold time
                next_ctrl.write_enable_n = 1'b1;
                next_timer = cycles(DATA_HOLD_CYC);
                next_state = ST_DHOLD;
            end
            ST_DHOLD: if (timer == '0) begin
                next_ctrl = CTRL_IDLE;
                next_dq_oe = 2'b00;
                next_done = 1'b1;
                next_timer = cycles(RECOVERY_CYC);
                next_state = ST_RECOVER;
            end
            ST_RECOVER: if (timer == '0) begin
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            timer <= '0;
            held <= '0;
            ctrl <= CTRL_IDLE;
            addr_out <= '0;
            dq_out <= '0;
            dq_oe <= 2'b00;
            rdata <= '0;
            done <= 1'b0;
            req_ready <= 1'b1;
        end else begin
            state <= next_state;
            timer <= next_timer;
            held <= next_held;
            ctrl <= next_ctrl;
            addr_out <= next_addr_out;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
            rdata <= next_rdata;
            done <= next_done;
            req_ready <= (next_state == ST_IDLE);
        end
    end

endmodule

// ==== design/dpram_host.sv ====
// Host controller driving both ports of an asynchronous dual-port SRAM.
// Assumes one clock, synchronous reset, and flags sampled as synchronous.
//
// Operation
// - right port mode pin selects standard or muxed
// - muxed address on bus, latched on strobe rise
// - write enable high reads; host frees bus
// - muxed write drives data after address hold
// - standard mode takes address from address pins
// - standard mode write enable and data drive
module dpram_host
    import dpram_host_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mode_muxed_cfg,
    input wire logic special_function_cfg,
    input wire logic left_req_valid,
    input wire host_req_t left_req,
    output logic left_req_ready,
    output logic left_done,
    output logic [DATA_W-1:0] left_rdata,
    output logic left_mailbox_pending,
    output logic left_collision_seen,
    input wire logic right_req_valid,
    input wire host_req_t right_req,
    output logic right_req_ready,
    output logic right_done,
    output logic [DATA_W-1:0] right_rdata,
    output logic right_mailbox_pending,
    output logic right_collision_seen,
    output port_ctrl_t left_ctrl,
    output logic [DATA_W-1:0] left_dq_out,
    output logic [1:0] left_dq_oe,
    input wire logic [DATA_W-1:0] left_dq_in,
    input wire logic left_busy_n,
    input wire logic left_int_n,
    output port_ctrl_t right_ctrl,
    output logic [ADDR_W-1:0] right_addr,
    output logic [DATA_W-1:0] right_dq_out,
    output logic [1:0] right_dq_oe,
    input wire logic [DATA_W-1:0] right_dq_in,
    input wire logic right_busy_n,
    input wire logic right_int_n,
    output logic right_port_mode_select,
    output logic special_function_enable_n
);

    // ------------------------------------------------------------
    // Mode pins
    // ------------------------------------------------------------
    // Mode only changes between accesses so a sequence never sees it flip
    logic mode_q, next_mode_q, special_function_enable_n_n_q, next_special_function_enable_n_n_q;
    logic l_ready, r_ready, l_done_i, r_done_i;
    logic [DATA_W-1:0] l_rdata_i, r_rdata_i;
    port_ctrl_t l_ctrl_i, r_ctrl_i;
    logic [DATA_W-1:0] l_dq_i, r_dq_i;
    logic [1:0] l_oe_i, r_oe_i;
    logic [ADDR_W-1:0] r_addr_i;
    logic l_mbox, r_mbox, l_coll, r_coll;
    logic next_l_mbox, next_r_mbox, next_l_coll, next_r_coll;

    always_comb begin
        next_mode_q = mode_q;
        next_special_function_enable_n_n_q = special_function_enable_n_n_q;
        if (l_ready && r_ready && !left_req_valid && !right_req_valid) begin
            next_mode_q = mode_muxed_cfg ? MODE_MUXED : MODE_STANDARD;
            next_special_function_enable_n_n_q = ~special_function_cfg;
        end
    end

    // ------------------------------------------------------------
    // Port sequencers
    // ------------------------------------------------------------
    // Left is always muxed; both run with no interlock
    dpram_port_seq left_seq (
        .clock(clock),
        .sys_rst(sys_rst),
        .muxed(MODE_MUXED),
        .req_valid(left_req_valid),
        .req(left_req),
        .req_ready(l_ready),
        .done(l_done_i),
        .rdata(l_rdata_i),
        .ctrl(l_ctrl_i),
        .addr_out(),
        .dq_out(l_dq_i),
        .dq_oe(l_oe_i),
        .dq_in(left_dq_in)
    );

    dpram_port_seq right_seq (
        .clock(clock),
        .sys_rst(sys_rst),
        .muxed(mode_q),
        .req_valid(right_req_valid),
        .req(right_req),
        .req_ready(r_ready),
        .done(r_done_i),
        .rdata(r_rdata_i),
        .ctrl(r_ctrl_i),
        .addr_out(r_addr_i),
        .dq_out(r_dq_i),
        .dq_oe(r_oe_i),
        .dq_in(right_dq_in)
    );

    // ------------------------------------------------------------
    // Device flag tracking
    // ------------------------------------------------------------
    // Collision seen is sticky per access; a new request clears it, set wins
    always_comb begin
        next_l_mbox = ~left_int_n;
        next_r_mbox = ~right_int_n;
        next_l_coll = l_coll;
        next_r_coll = r_coll;
        if (left_req_valid && l_ready) begin
            next_l_coll = 1'b0;
        end
        if (right_req_valid && r_ready) begin
            next_r_coll = 1'b0;
        end
        if (!left_busy_n && !l_ctrl_i.chip_select_n) begin
            next_l_coll = 1'b1;
        end
        if (!right_busy_n && !r_ctrl_i.chip_select_n) begin
            next_r_coll = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_q <= MODE_STANDARD;
            special_function_enable_n_n_q <= 1'b1;
            l_mbox <= 1'b0;
            r_mbox <= 1'b0;
            l_coll <= 1'b0;
            r_coll <= 1'b0;
        end else begin
            mode_q <= next_mode_q;
            special_function_enable_n_n_q <= next_special_function_enable_n_n_q;
            l_mbox <= next_l_mbox;
            r_mbox <= next_r_mbox;
            l_coll <= next_l_coll;
            r_coll <= next_r_coll;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Sequencer outputs are already flip-flops; the standard path never
    // lowers the right strobe, so it idles high there
    assign right_ctrl = r_ctrl_i;

    assign left_req_ready = l_ready;
    assign right_req_ready = r_ready;
    assign left_done = l_done_i;
    assign right_done = r_done_i;
    assign left_rdata = l_rdata_i;
    assign right_rdata = r_rdata_i;
    assign left_ctrl = l_ctrl_i;
    assign left_dq_out = l_dq_i;
    assign left_dq_oe = l_oe_i;
    assign right_addr = r_addr_i;
    assign right_dq_out = r_dq_i;
    assign right_dq_oe = r_oe_i;
    assign left_mailbox_pending = l_mbox;
    assign right_mailbox_pending = r_mbox;
    assign left_collision_seen = l_coll;
    assign right_collision_seen = r_coll;
    assign right_port_mode_select = mode_q;
    assign special_function_enable_n = special_function_enable_n_n_q;

endmodule

// ==== tb/dpram_host_props.sv ====
// Concurrent checks on the host controller's pins.
// Assumes one clock and the synchronous active-high reset of the top module.
module dpram_host_props
    import dpram_host_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic left_req_ready,
    input wire port_ctrl_t left_ctrl,
    input wire logic [1:0] left_dq_oe,
    input wire logic left_busy_n,
    input wire logic left_collision_seen,
    input wire port_ctrl_t right_ctrl,
    input wire logic [ADDR_W-1:0] right_addr,
    input wire logic right_port_mode_select
);
    // ------------------------------------------------------------
    // Port sequencing properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Address phase: both lanes driven, strobe low two cycles, then rising
    sequence s_addr_phase;
        (!left_ctrl.address_latch_strobe_n && left_dq_oe == 2'b11) [*2]
            ##1 left_ctrl.address_latch_strobe_n;
    endsequence
    // Write pulse of six cycles before the committing rise
    sequence s_write_pulse;
        !left_ctrl.write_enable_n [*6] ##1 left_ctrl.write_enable_n;
    endsequence

    a_latch_phase: assert property ($fell(left_ctrl.address_latch_strobe_n)
        |-> s_addr_phase)
        else $error("address phase malformed");
    a_latch_selected: assert property (!$past(sys_rst) && $rose(left_ctrl.address_latch_strobe_n)
        |-> !left_ctrl.chip_select_n)
        else $error("address latched while deselected");
    a_write_pulse: assert property ($fell(left_ctrl.write_enable_n) |-> s_write_pulse)
        else $error("write pulse length wrong");
    a_write_hold: assert property (!$past(sys_rst) && $rose(left_ctrl.write_enable_n)
        |-> !left_ctrl.chip_select_n && $stable(left_dq_oe))
        else $error("write data not held at commit");
    a_byte_lanes: assert property (!left_ctrl.write_enable_n |-> left_dq_oe ==
        {~left_ctrl.high_byte_enable_n, ~left_ctrl.low_byte_enable_n})
        else $error("driven lanes differ from byte enables");
    a_bus_float: assert property (left_ctrl.chip_select_n |-> left_dq_oe == 2'b00)
        else $error("bus driven while deselected");
    a_host_quiet: assert property (!left_ctrl.output_enable_n |-> left_dq_oe == 2'b00)
        else $error("host drives during read");
    a_we_oe_excl: assert property (!right_ctrl.write_enable_n
        |-> right_ctrl.output_enable_n)
        else $error("output enable during write");
    a_std_strobe: assert property (!right_port_mode_select
        |-> right_ctrl.address_latch_strobe_n)
        else $error("strobe pulsed in standard mode");
    a_std_addr: assert property (!right_ctrl.chip_select_n && !$past(right_ctrl.chip_select_n)
        |-> $stable(right_addr))
        else $error("address moved during access");
    a_collision_flag: assert property (!left_busy_n && !left_ctrl.chip_select_n
        |=> left_collision_seen)
        else $error("collision not recorded");
    a_idle_ctrl: assert property (left_req_ready |-> left_ctrl == CTRL_IDLE)
        else $error("idle port not deselected");
endmodule

bind dpram_host dpram_host_props chk_u (.*);

// ==== tb/dpram_dev_model.sv ====
// Behavioural dual-port SRAM as seen from both host ports.
// Assumes host pins change just after the clock and are sampled here on it.
module dpram_dev_model
    import dpram_host_pkg::*;
(
    input wire logic clock,
    input wire port_ctrl_t left_ctrl,
    input wire logic [DATA_W-1:0] left_dq_out,
    input wire logic [1:0] left_dq_oe,
    input wire port_ctrl_t right_ctrl,
    input wire logic [ADDR_W-1:0] right_addr,
    input wire logic [DATA_W-1:0] right_dq_out,
    input wire logic [1:0] right_dq_oe,
    input wire logic right_port_mode_select,
    input wire logic special_function_enable_n,
    output logic [DATA_W-1:0] left_dq_in,
    output logic [DATA_W-1:0] right_dq_in,
    output logic left_busy_n,
    output logic right_busy_n,
    output logic left_int_n,
    output logic right_int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Storage and port views
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] open_drain_output_register = 16'h0000;
    logic [1:0] irq = 2'b11; // Both pending at power-up until owners read
    port_ctrl_t c [2], pc [2];
    logic [DATA_W-1:0] hd [2], din [2], last [2];
    logic [1:0] hoe [2];
    logic [ADDR_W-1:0] lat [2], a [2], pa [2];

    // Port wiring; right address source follows the mode pin
    assign c[0] = left_ctrl;
    assign c[1] = right_ctrl;
    assign hd[0] = left_dq_out;
    assign hd[1] = right_dq_out;
    assign hoe[0] = left_dq_oe;
    assign hoe[1] = right_dq_oe;
    assign a[0] = lat[0];
    assign a[1] = right_port_mode_select ? lat[1] : right_addr;
    assign left_dq_in = din[0];
    assign right_dq_in = din[1];
    assign left_busy_n = !(!c[0].chip_select_n && !c[1].chip_select_n && a[0] == a[1]);
    assign right_busy_n = left_busy_n;
    assign left_int_n = ~irq[0];
    assign right_int_n = ~irq[1];

    // Bus level per lane; a floating lane shows the inverse of its last value
    always_comb begin
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < 2; i++) begin
            r = (!special_function_enable_n && a[i] == OUTPUT_DRIVE_ADDR) ? open_drain_output_register : mem[a[i]];
            for (int b = 0; b < 2; b++) begin
                if (hoe[i][b])
                    din[i][b*8 +: 8] = hd[i][b*8 +: 8];
                else if (!c[i].chip_select_n && !c[i].output_enable_n && c[i].write_enable_n
                         && !(b ? c[i].high_byte_enable_n : c[i].low_byte_enable_n))
                    din[i][b*8 +: 8] = r[b*8 +: 8];
                else
                    din[i][b*8 +: 8] = ~last[i][b*8 +: 8];
            end
        end
    end

    // Address latch on strobe rise, write on first rise of enable or select
    always @(posedge clock) begin
        for (int i = 0; i < 2; i++) begin
            pc[i] <= c[i];
            pa[i] <= a[i];
            last[i] <= din[i];
            if (!pc[i].address_latch_strobe_n && c[i].address_latch_strobe_n
                && (i == 0 || right_port_mode_select))
                lat[i] <= hd[i][ADDR_W-1:0];
            if (!pc[i].chip_select_n && !pc[i].write_enable_n
                && (c[i].write_enable_n || c[i].chip_select_n)) begin
                if (!special_function_enable_n && a[i] == OUTPUT_DRIVE_ADDR)
                    open_drain_output_register <= hd[i] & ODR_FIELD_MASK;
                else begin
                    if (!pc[i].high_byte_enable_n) mem[a[i]][15:8] <= hd[i][15:8];
                    if (!pc[i].low_byte_enable_n) mem[a[i]][7:0] <= hd[i][7:0];
                end
                if (a[i] == (i ? LEFT_MAILBOX_ADDR : RIGHT_MAILBOX_ADDR))
                    irq[1-i] <= 1'b1;
            end
            if (!pc[i].chip_select_n && pc[i].write_enable_n && c[i].chip_select_n
                && pa[i] == (i ? RIGHT_MAILBOX_ADDR : LEFT_MAILBOX_ADDR))
                irq[i] <= 1'b0;
        end
    end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the dual-port SRAM host controller.
// Assumes the device model on both ports and the bound checker.
module tb
    import dpram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus, reference and checks
    // ------------------------------------------------------------
    logic clock = 1'b0, sys_rst = 1'b1, mode_muxed_cfg = 1'b0, special_function_cfg = 1'b0;
    logic left_req_valid = 1'b0, right_req_valid = 1'b0;
    host_req_t left_req = '0, right_req = '0;
    logic left_req_ready, left_done, left_mailbox_pending, left_collision_seen;
    logic right_req_ready, right_done, right_mailbox_pending, right_collision_seen;
    logic [DATA_W-1:0] left_rdata, right_rdata, left_dq_out, right_dq_out;
    logic [DATA_W-1:0] left_dq_in, right_dq_in, q, q2;
    logic [1:0] left_dq_oe, right_dq_oe;
    port_ctrl_t left_ctrl, right_ctrl;
    logic [ADDR_W-1:0] right_addr;
    logic left_busy_n, right_busy_n, left_int_n, right_int_n;
    logic right_port_mode_select, special_function_enable_n;
    int bad_count = 0, compares = 0, seed = 36451;
    logic [DATA_W-1:0] ref_m [8]; // Words held at the eight test addresses

    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    dpram_host dut_u (.*);
    dpram_dev_model dev_u (.*);

    task automatic check(input logic [DATA_W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Disabled byte lanes read as zero
    function automatic logic [DATA_W-1:0] lanes(input logic [DATA_W-1:0] d,
                                               input logic [1:0] be);
        lanes = {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
    endfunction

    // Spread test words over the whole address range, clear of special places
    function automatic logic [ADDR_W-1:0] addr_of(input logic [2:0] k);
        addr_of = 14'h0002 + {k, 11'h000};
    endfunction

    // One access: hold the request until taken, then wait for done
    task automatic op(input bit p, input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [1:0] be,
                      output logic [DATA_W-1:0] rq);
        int n = 0;
        @(negedge clock);
        if (p) begin
            right_req = '{w, a, d, be[1], be[0]};
            right_req_valid = 1'b1;
        end else begin
            left_req = '{w, a, d, be[1], be[0]};
            left_req_valid = 1'b1;
        end
        while ((p ? right_req_ready : left_req_ready) !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        if (p) right_req_valid = 1'b0;
        else left_req_valid = 1'b0;
        while ((p ? right_done : left_done) !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        rq = p ? right_rdata : left_rdata;
        if (n >= 100) begin
            bad_count++;
            $display("[ERR] %0t port wait ran out", $time);
            conclude();
        end
    endtask

    // Random reads and writes on either port with random byte enables
    task automatic traffic(input int count);
        logic [2:0] k;
        logic [1:0] be;
        logic w;
        logic [DATA_W-1:0] d, r;
        for (int i = 0; i < count; i++) begin
            k = 3'($random(seed));
            be = 2'($random(seed));
            w = 1'($random(seed));
            d = 16'($random(seed));
            op(1'($random(seed)), w, addr_of(k), d, be, r);
            if (w) ref_m[k] = lanes(d, be) | lanes(ref_m[k], ~be);
            else check(r, lanes(ref_m[k], be));
        end
    endtask

    initial begin
        logic [DATA_W-1:0] d;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        check(16'(left_ctrl), 16'(CTRL_IDLE));
        check(16'({right_dq_oe, right_port_mode_select, special_function_enable_n}), 16'h1);
        // Pending flags are registered, so they show the pins one edge after reset
        @(negedge clock);
        check(16'({left_mailbox_pending, right_mailbox_pending}), 16'h3);
        // Owners read their own mailboxes, then left posts to the right one
        op(0, 0, LEFT_MAILBOX_ADDR, 16'h0000, 2'b11, q);
        op(1, 0, RIGHT_MAILBOX_ADDR, 16'h0000, 2'b11, q);
        repeat (3) @(negedge clock);
        check(16'({left_mailbox_pending, right_mailbox_pending}), 16'h0);
        op(0, 1, RIGHT_MAILBOX_ADDR, 16'hA5C3, 2'b11, q);
        repeat (3) @(negedge clock);
        check(16'({left_mailbox_pending, right_mailbox_pending}), 16'h1);
        op(1, 0, RIGHT_MAILBOX_ADDR, 16'h0000, 2'b11, q);
        check(q, 16'hA5C3);
        repeat (3) @(negedge clock);
        check(16'(right_mailbox_pending), 16'h0);
        for (int m = 0; m < 2; m++) begin
            mode_muxed_cfg = m[0];
            repeat (4) @(negedge clock);
            check(16'(right_port_mode_select), 16'(m));
            for (int k = 0; k < 8 && m == 0; k++) begin
                d = 16'($random(seed));
                op(k[0], 1, addr_of(k[2:0]), d, 2'b11, q);
                ref_m[k] = d;
            end
            traffic(40);
            // Overlapping writes to distinct words, then both read one word
            fork
                op(0, 1, addr_of(3'd1), 16'h1234 + 16'(m), 2'b11, q);
                op(1, 1, addr_of(3'd2), 16'hFEDC, 2'b11, q2);
            join
            ref_m[1] = 16'h1234 + 16'(m);
            ref_m[2] = 16'hFEDC;
            fork
                op(0, 0, addr_of(3'd1), 16'h0000, 2'b11, q);
                op(1, 0, addr_of(3'd1), 16'h0000, 2'b11, q2);
            join
            check(q, ref_m[1]);
            check(q2, ref_m[1]);
            check(16'({left_collision_seen, right_collision_seen}), 16'h3);
        end
        // Special function on: only the output-drive field reads back
        special_function_cfg = 1'b1;
        repeat (4) @(negedge clock);
        check(16'(special_function_enable_n), 16'h0);
        op(1, 1, OUTPUT_DRIVE_ADDR, 16'hFFFF, 2'b11, q);
        op(0, 0, OUTPUT_DRIVE_ADDR, 16'h0000, 2'b11, q);
        check(q, ODR_FIELD_MASK);
        conclude();
    end
endmodule
